//--- hw/pcc_peak_current_ctrl.v
// Overview of operation
// - Gate turns on at each cycle start
// - Gate off when current exceeds reference
// - Comparator against reference ends on-time
// - Reference falls by slope times elapsed time
// - Zero slope keeps reference constant
// - Blanking time ignores trips at start
// - Cycles repeat at configured carrier period
// - Complementary mode drives inverted A/B pair
// - Blanking delay between opposing pair edges
// - Single mode modulates only channel A
// - Polarity sets the active level of both A and B
// - Sense source selects ADC or amplifier
// - ADC trigger after divided event count
// - Task trigger after divided event count

`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.vh"

module pcc_peak_current_ctrl #(
   parameter DW = 12,
   parameter TW = 16,
   parameter VW = 4
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          ce,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   input  wire [3:0]    pstrb,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   input  wire [DW-1:0] sense_adc,
   input  wire [DW-1:0] sense_amp,
   output reg  [DW-1:0] peak_reference,
   output wire          gate_out_primary,
   output wire          gate_out_secondary,
   output wire          adc_trig,
   output wire          task_trig
);

   // Configuration registers
   reg [7:0]    ctrl_q;
   reg [TW-1:0] period_q;
   reg [DW-1:0] ref_q;
   reg [DW-1:0] slope_q;
   reg [DW-1:0] offset_q;
   reg [TW-1:0] blank_q;
   reg [TW-1:0] dead_q;
   reg [VW-1:0] adc_div_q;
   reg [VW-1:0] task_div_q;

   // Cycle state, all of it frozen while ce is low
   reg [TW-1:0]   cnt_q;
   reg [DW+TW:0]  ramp_q;
   reg            on_q;
   reg            tripped_q;
   reg            cmp_q;
   reg            start_q;
   reg            trip_ev_q;
   reg            period_ev_q;

   // Bus decode
   wire           en;
   wire           wr;
   wire           rd;

   // Carrier timing, sense path and reference arithmetic
   wire           cyc_start;
   wire           cyc_end;
   wire [DW-1:0]  sense;
   wire [DW:0]    base;
   wire [DW+TW:0] ref_full;
   wire [DW+TW:0] ref_diff;
   wire           ref_over;
   wire [DW-1:0]  eff_ref;
   wire           in_blank;
   wire           trip_now;

   // Read mux outputs
   reg  [31:0]    rdata_d;
   reg            err_d;

   // Select one event source for a divider
   // Code 3 and any unknown code select no event, so the divider idles
   function ev_sel;
      input [1:0] sel;
      input       s;
      input       t;
      input       p;
      begin
         case (sel)
            `PCC_EV_START:  ev_sel = s;
            `PCC_EV_TRIP:   ev_sel = t;
            `PCC_EV_PERIOD: ev_sel = p;
            default:        ev_sel = 1'b0;
         endcase
      end
   endfunction

   // Master enable for carrier, trips and triggers
   assign en = ctrl_q[`PCC_CTRL_EN];

   // APB access phase takes two cycles, as pready is registered and set in the second
   // The ~pready term keeps a held request from acting twice
   assign wr = psel & penable & pwrite & ~pready;
   assign rd = psel & penable & ~pwrite & ~pready;

   // Register writes; byte lanes are not honoured on any register
   // Any strobe bit writes the whole register; none at all writes nothing
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q     <= `PCC_RST_CTRL;
         period_q   <= `PCC_RST_PERIOD;
         ref_q      <= {DW{1'b0}};
         slope_q    <= {DW{1'b0}};
         offset_q   <= {DW{1'b0}};
         blank_q    <= `PCC_RST_BLANK;
         dead_q     <= `PCC_RST_DEAD;
         adc_div_q  <= `PCC_RST_DIV;
         task_div_q <= `PCC_RST_DIV;
      end else if (ce && wr && (pstrb != 4'h0)) begin
         case (paddr)
            `PCC_OFF_CTRL:   ctrl_q   <= pwdata[7:0];
            `PCC_OFF_PERIOD: period_q <= pwdata[TW-1:0];
            `PCC_OFF_REF:    ref_q    <= pwdata[DW-1:0];
            `PCC_OFF_SLOPE:  slope_q  <= pwdata[DW-1:0];
            `PCC_OFF_OFFSET: offset_q <= pwdata[DW-1:0];
            `PCC_OFF_BLANK:  blank_q  <= pwdata[TW-1:0];
            `PCC_OFF_DEAD:   dead_q   <= pwdata[TW-1:0];
            // Both trigger dividers share one word
            `PCC_OFF_DIV: begin
               adc_div_q  <= pwdata[VW-1:0];
               task_div_q <= pwdata[VW+15:16];
            end
            // Status is read-only; unmapped offsets are refused by the error flag
            default: ;
         endcase
      end
   end

   // Read mux and decode error for unmapped offsets
   // Decode is exact, so unaligned offsets also read as unmapped
   always @* begin
      rdata_d = 32'h00000000;
      err_d   = 1'b0;
      case (paddr)
         `PCC_OFF_CTRL:   rdata_d[7:0]    = ctrl_q;
         `PCC_OFF_PERIOD: rdata_d[TW-1:0] = period_q;
         `PCC_OFF_REF:    rdata_d[DW-1:0] = ref_q;
         `PCC_OFF_SLOPE:  rdata_d[DW-1:0] = slope_q;
         `PCC_OFF_OFFSET: rdata_d[DW-1:0] = offset_q;
         `PCC_OFF_BLANK:  rdata_d[TW-1:0] = blank_q;
         `PCC_OFF_DEAD:   rdata_d[TW-1:0] = dead_q;
         `PCC_OFF_DIV: begin
            rdata_d[VW-1:0]    = adc_div_q;
            rdata_d[VW+15:16]  = task_div_q;
         end
         // Live cycle state, for polling the on-time and comparator
         `PCC_OFF_STATUS: begin
            rdata_d[0]         = on_q;
            rdata_d[1]         = tripped_q;
            rdata_d[2]         = cmp_q;
            rdata_d[TW+15:16]  = cnt_q;
         end
         default: err_d = 1'b1;
      endcase
   end

   // APB response registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         // One wait state: answer on the edge after the access is taken
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & err_d;
         // Read data holds until the next read; writes leave it alone
         if (rd) begin
            prdata <= rdata_d;
         end
      end
   end

   // Sense source selection
   assign sense     = ctrl_q[`PCC_CTRL_SRC] ? sense_amp : sense_adc;
   // Base is one bit wider so reference plus offset cannot wrap
   assign base      = {1'b0, ref_q} + {1'b0, offset_q};
   assign ref_full  = {{TW{1'b0}}, base};
   // Ramp grows by slope each clock; zero slope leaves it at zero
   assign ref_diff  = ref_full - ramp_q;
   assign ref_over  = (ref_diff > {{(TW+1){1'b0}}, {DW{1'b1}}});
   // Clamp at zero once the ramp passes the base, and at full scale on top
   assign eff_ref   = (ramp_q >= ref_full) ? {DW{1'b0}} :
                      ref_over ? {DW{1'b1}} :
                      ref_diff[DW-1:0];

   // Carrier end and blanking window
   // A period shortened below the count ends the cycle at once
   assign cyc_end   = (cnt_q >= period_q);
   assign cyc_start = en & cyc_end;
   // Trips are ignored while the count is inside the blanking time
   assign in_blank  = (cnt_q < blank_q);
   assign trip_now  = on_q & ~in_blank & cmp_q;

   // Carrier counter, ramp and on/off latch
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q          <= {TW{1'b0}};
         ramp_q         <= {(DW+TW+1){1'b0}};
         on_q           <= 1'b0;
         tripped_q      <= 1'b0;
         cmp_q          <= 1'b0;
         start_q        <= 1'b0;
         trip_ev_q      <= 1'b0;
         period_ev_q    <= 1'b0;
         peak_reference <= {DW{1'b0}};
      end else if (ce) begin
         // Comparator output is registered, one cycle of trip latency
         cmp_q          <= (sense > peak_reference);
         peak_reference <= eff_ref;
         // Event flags last one clock
         start_q        <= 1'b0;
         trip_ev_q      <= 1'b0;
         period_ev_q    <= 1'b0;

         // Disabled: gates off, count preloaded so enable starts a cycle next edge
         if (!en) begin
            cnt_q     <= period_q;
            ramp_q    <= {(DW+TW+1){1'b0}};
            on_q      <= 1'b0;
            tripped_q <= 1'b0;
         end else if (cyc_start) begin
            // New cycle: gate on with no set duty, ramp restarts from zero
            // Start and period events share one pulse, as cycles abut
            cnt_q       <= {TW{1'b0}};
            ramp_q      <= {(DW+TW+1){1'b0}};
            on_q        <= 1'b1;
            tripped_q   <= 1'b0;
            start_q     <= 1'b1;
            period_ev_q <= 1'b1;
         end else begin
            // Within the cycle: count, ramp, and the first trip ends the on-time
            // A trip that meets the cycle start is dropped; the new cycle wins
            cnt_q  <= cnt_q + {{(TW-1){1'b0}}, 1'b1};
            ramp_q <= ramp_q + {{(TW+1){1'b0}}, slope_q};
            if (trip_now && !tripped_q) begin
               on_q      <= 1'b0;
               tripped_q <= 1'b1;
               trip_ev_q <= 1'b1;
            end
         end
      end
   end

   // Output stage with polarity and blanking delay
   // Single mode and the idle level of channel B are settled inside the stage
   pcc_dead #(.W(TW)) u_dead (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .pwm     (on_q),
      .compl   (ctrl_q[`PCC_CTRL_COMPL]),
      .pol     (ctrl_q[`PCC_CTRL_POL]),
      .dead    (dead_q),
      .out_a_q (gate_out_primary),
      .out_b_q (gate_out_secondary)
   );

   // Trigger dividers for ADC and control task
   // Each trigger is one clock wide; divider d fires on every (d+1)-th event
   // Dividers restart while disabled, so a new run counts from zero
   pcc_evdiv #(.W(VW)) u_adc_div (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .clr     (~en),
      .ev      (ev_sel(ctrl_q[`PCC_CTRL_ADCEV], start_q, trip_ev_q, period_ev_q)),
      .div     (adc_div_q),
      .trig_q  (adc_trig)
   );

   pcc_evdiv #(.W(VW)) u_task_div (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .clr     (~en),
      .ev      (ev_sel(ctrl_q[`PCC_CTRL_TASKEV], start_q, trip_ev_q, period_ev_q)),
      .div     (task_div_q),
      .trig_q  (task_trig)
   );
endmodule // pcc_peak_current_ctrl
`default_nettype wire

//--- hw/pcc_defines.vh
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH
// APB register byte offsets
`define PCC_OFF_CTRL      12'h000
`define PCC_OFF_PERIOD    12'h004
`define PCC_OFF_REF       12'h008
`define PCC_OFF_SLOPE     12'h00C
`define PCC_OFF_OFFSET    12'h010
`define PCC_OFF_BLANK     12'h014
`define PCC_OFF_DEAD      12'h018
`define PCC_OFF_DIV       12'h01C
`define PCC_OFF_STATUS    12'h020
// Control register fields
`define PCC_CTRL_EN       0
`define PCC_CTRL_COMPL    1
`define PCC_CTRL_POL      2
`define PCC_CTRL_SRC      3
`define PCC_CTRL_ADCEV    5:4
`define PCC_CTRL_TASKEV   7:6
// Reset values
`define PCC_RST_CTRL      8'h00
`define PCC_RST_PERIOD    16'h07CF
`define PCC_RST_BLANK     16'h0004
`define PCC_RST_DEAD      16'h0002
`define PCC_RST_DIV       4'h0
// Event selections
`define PCC_EV_START      2'h0
`define PCC_EV_TRIP       2'h1
`define PCC_EV_PERIOD     2'h2
`endif

//--- hw/pcc_evdiv.v
`timescale 1ns/1ps
`default_nettype none
// Event divider: pulses once per (div+1) selected events
module pcc_evdiv #(
   parameter W = 4
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         ce,
   input  wire         clr,
   input  wire         ev,
   input  wire [W-1:0] div,
   output reg          trig_q
);
   reg [W-1:0] cnt_q;
   // Count events; fire when the count reaches the divider
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= {W{1'b0}};
         trig_q <= 1'b0;
      end else if (ce) begin
         trig_q <= 1'b0;
         if (clr) begin
            cnt_q <= {W{1'b0}};
         end else if (ev) begin
            if (cnt_q >= div) begin
               cnt_q  <= {W{1'b0}};
               trig_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // pcc_evdiv
`default_nettype wire

//--- hw/pcc_dead.v
`timescale 1ns/1ps
`default_nettype none
// Complementary pair with blanking delay on each rising edge
module pcc_dead #(
   parameter W = 16
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         ce,
   input  wire         pwm,
   input  wire         compl,
   input  wire         pol,
   input  wire [W-1:0] dead,
   output reg          out_a_q,
   output reg          out_b_q
);
   reg         pwm_q;
   reg [W-1:0] dly_q;
   wire        a_act;
   wire        b_act;
   // Both outputs stay inactive while the delay runs after any edge
   assign a_act = pwm & pwm_q & (dly_q == {W{1'b0}});
   assign b_act = compl & ~pwm & ~pwm_q & (dly_q == {W{1'b0}});
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_q   <= 1'b0;
         dly_q   <= {W{1'b0}};
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
      end else if (ce) begin
         pwm_q <= pwm;
         if (pwm != pwm_q) begin
            dly_q <= compl ? dead : {W{1'b0}};
         end else if (dly_q != {W{1'b0}}) begin
            dly_q <= dly_q - {{(W-1){1'b0}}, 1'b1};
         end
         out_a_q <= a_act ^ ~pol;
         // Single mode leaves B idle at the inverse of A's idle level
         // In complementary mode B shares A's polarity mapping, so the pair never shows both active
         out_b_q <= compl ? (b_act ^ ~pol) : pol;
      end
   end
endmodule // pcc_dead
`default_nettype wire

//--- test/pcc_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_sense_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        gate_on,
   input  wire logic [11:0] rate,
   output var  logic [11:0] sense_adc,
   output wire logic [11:0] sense_amp
);
   // Inductor current climbs while the switch conducts, dumped when it opens
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sense_adc <= 12'h000;
      else if (!gate_on)
         sense_adc <= 12'h000;
      else if (sense_adc < 12'hF00)
         sense_adc <= sense_adc + rate;
   end
   // Amplifier path sees half the swing, so its trip comes later
   assign sense_amp = {1'b0, sense_adc[11:1]};
endmodule // pcc_sense_model
`default_nettype wire

//--- test/pcc_props.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        gate_out_primary,
   input wire logic        gate_out_secondary,
   input wire logic        adc_trig,
   input wire logic        task_trig
);
   logic [7:0] ctrl_q;
   // Shadow of the control word, so each check knows the mode
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_q <= 8'h00;
      else if (ce && psel && penable && pready && pwrite && |pstrb && paddr == 12'h000)
         ctrl_q <= pwdata[7:0];
   end
   // Modes with A active high; other polarity is covered by the idle check
   wire one_m = ctrl_q[0] & ctrl_q[2] & ~ctrl_q[1];
   wire two_m = ctrl_q[0] & ctrl_q[2] & ctrl_q[1];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Mode changes settle over two edges, so checks wait for a steady word
   sequence s_cfg;
      $stable(ctrl_q)[*3];
   endsequence
   property p_rdy; psel && penable && !pready |=> pready; endproperty
   property p_err; psel && penable && pready && paddr > 12'h020 |-> pslverr; endproperty
   property p_idle; s_cfg ##0 !ctrl_q[0] |-> gate_out_primary == !ctrl_q[2] && gate_out_secondary == ctrl_q[2];
   endproperty
   property p_one; s_cfg ##0 one_m |-> gate_out_secondary; endproperty
   property p_blank; s_cfg ##0 one_m && $rose(gate_out_primary) |-> gate_out_primary[*4]; endproperty
   property p_pair; s_cfg ##0 two_m |-> !(gate_out_primary && gate_out_secondary); endproperty
   property p_dead; s_cfg ##0 two_m && $fell(gate_out_primary) |-> !gate_out_secondary[*2]; endproperty
   property p_adc; adc_trig |=> !adc_trig; endproperty
   property p_task; task_trig |=> !task_trig; endproperty
   a_rdy: assert property (p_rdy) else $error("ready not after one wait");
   a_err: assert property (p_err) else $error("unmapped access without error");
   a_idle: assert property (p_idle) else $error("disabled gates not inactive");
   a_one: assert property (p_one) else $error("channel B moved in single mode");
   a_blank: assert property (p_blank) else $error("on time below blanking");
   a_pair: assert property (p_pair) else $error("both gates on");
   a_dead: assert property (p_dead) else $error("no delay before B");
   a_adc: assert property (p_adc) else $error("adc trigger too long");
   a_task: assert property (p_task) else $error("task trigger too long");
endmodule // pcc_props
bind pcc_peak_current_ctrl pcc_props u_props (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .pready, .pslverr, .gate_out_primary, .gate_out_secondary, .adc_trig, .task_trig);
`default_nettype wire

//--- test/pcc_peak_current_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.vh"
module pcc_peak_current_ctrl_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hF;
   logic [11:0] rate = 12'h000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [11:0] peak_reference;
   logic [11:0] sense_adc;
   logic [11:0] sense_amp;
   logic        gate_out_primary;
   logic        gate_out_secondary;
   logic        adc_trig;
   logic        task_trig;
   logic [31:0] rd;
   logic        er;
   logic [11:0] p1;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cyc = 0;
   pcc_peak_current_ctrl dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .sense_adc, .sense_amp, .peak_reference, .gate_out_primary,
      .gate_out_secondary, .adc_trig, .task_trig);
   pcc_sense_model u_sense (.pclk, .presetn, .gate_on(gate_out_primary), .rate, .sense_adc, .sense_amp);
   always #12.5 pclk = ~pclk;
   // Hang guard; the whole run needs a few thousand cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         give_verdict;
      end
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task rng(input string nm, input int n, input int lo, input int hi);
      chk(nm, {31'h0, n >= lo && n <= hi}, 32'h1);
   endtask
   // Request held until pready is seen high at an edge
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] x, input logic e);
      apb(a, 1'b0, 32'h0);
      chk("rdata", rd, x);
      chk("slverr", {31'h0, er}, {31'h0, e});
   endtask
   // Edges from gate A turning on until it is seen off
   task on_time(output int n);
      @(posedge gate_out_primary);
      n = 0;
      while (gate_out_primary === 1'b1) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task ref_at(input int k, input logic [11:0] x);
      @(posedge gate_out_primary);
      repeat (k) @(posedge pclk);
      chk("peak_ref", {20'h0, peak_reference}, {20'h0, x});
   endtask
   task t_regs;
      rchk(`PCC_OFF_PERIOD, 32'h7CF, 1'b0);
      rchk(`PCC_OFF_BLANK, 32'h4, 1'b0);
      rchk(`PCC_OFF_DEAD, 32'h2, 1'b0);
      rchk(`PCC_OFF_CTRL, 32'h0, 1'b0);
      rchk(12'h024, 32'h0, 1'b1);
      pstrb <= 4'h0;
      wr(`PCC_OFF_PERIOD, 32'h5);
      pstrb <= 4'hF;
      rchk(`PCC_OFF_PERIOD, 32'h7CF, 1'b0);
      chk("gate_a", gate_out_primary, 32'h1);
      chk("gate_b", gate_out_secondary, 32'h0);
      $display("test regs done");
   endtask
   task t_single;
      int n;
      int t0;
      wr(`PCC_OFF_PERIOD, 32'h63);
      wr(`PCC_OFF_REF, 32'hC8);
      wr(`PCC_OFF_SLOPE, 32'h0);
      rate <= 12'h00A;
      wr(`PCC_OFF_CTRL, 32'hF5);
      on_time(n);
      rng("on_adc", n, 20, 29);
      chk("gate_b", gate_out_secondary, 32'h1);
      @(posedge gate_out_primary);
      t0 = int'($time);
      @(posedge gate_out_primary);
      rng("period", (int'($time) - t0) / 25, 100, 100);
      wr(`PCC_OFF_CTRL, 32'hFD);
      on_time(n);
      rng("on_amp", n, 40, 49);
      wr(`PCC_OFF_REF, 32'h0);
      on_time(n);
      rng("on_blank", n, 5, 9);
      $display("test single done");
   endtask
   task t_slope;
      rate <= 12'h003;
      wr(`PCC_OFF_OFFSET, 32'h32);
      wr(`PCC_OFF_REF, 32'hC8);
      ref_at(10, 12'h0FA);
      ref_at(60, 12'h0FA);
      wr(`PCC_OFF_SLOPE, 32'h3);
      @(posedge gate_out_primary);
      repeat (10) @(posedge pclk);
      p1 = peak_reference;
      @(posedge pclk);
      chk("ramp", {20'h0, p1 - peak_reference}, 32'h3);
      wr(`PCC_OFF_SLOPE, 32'h64);
      ref_at(3, 12'h000);
      $display("test slope done");
   endtask
   task t_compl;
      int n;
      rate <= 12'h00A;
      wr(`PCC_OFF_SLOPE, 32'h0);
      wr(`PCC_OFF_DEAD, 32'h5);
      wr(`PCC_OFF_CTRL, 32'hF7);
      @(posedge gate_out_primary);
      @(negedge gate_out_primary);
      n = 0;
      while (gate_out_secondary !== 1'b1) begin
         @(posedge pclk);
         n++;
      end
      rng("dead", n, 5, 7);
      chk("pair_a", gate_out_primary, 32'h0);
      $display("test compl done");
   endtask
   task t_trig;
      int na;
      int nt;
      wr(`PCC_OFF_PERIOD, 32'h13);
      wr(`PCC_OFF_REF, 32'h64);
      wr(`PCC_OFF_OFFSET, 32'h0);
      wr(`PCC_OFF_DIV, 32'h1);
      // Every event code in turn; the task trigger follows period events
      for (int e = 0; e < 4; e++) begin
         wr(`PCC_OFF_CTRL, 32'h85 | (e << 4));
         repeat (40) @(posedge pclk);
         na = 0;
         nt = 0;
         repeat (120) begin
            @(posedge pclk);
            na += adc_trig;
            nt += task_trig;
         end
         rng("adc_trig", na, (e == 3) ? 0 : 3, (e == 3) ? 0 : 3);
         rng("task_trig", nt, 6, 6);
      end
      $display("test trig done");
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_single;
      t_slope;
      t_compl;
      t_trig;
      give_verdict;
   end
endmodule // pcc_peak_current_ctrl_tb
`default_nettype wire
